// ### plsd_pkg.sv
/*
 * constants, register map and carrier types of the loop start-up and divider block.
 * assumes one 20 MHz oscillator clock and an AXI4-Lite master with 32-bit data.
 */
package plsd_pkg;
	localparam int          CLK_HZ         = 20_000_000;
	localparam logic [7:0]  ADDR_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_DIV       = 8'h04;
	localparam logic [7:0]  ADDR_STAT      = 8'h08;
	localparam logic [7:0]  ADDR_FAULT     = 8'h0c;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	// control: bit0 source disable, bit1 newer silicon timing
	localparam int          CTRL_DIS_BIT   = 0;
	localparam int          CTRL_NEW_BIT   = 1;
	localparam logic [1:0]  CTRL_RESET     = 2'h3;
	// divider: [5:0] input divider, [12:8] output ratio minus one
	localparam int          DIV_IN_LSB     = 0;
	localparam int          DIV_OUT_LSB    = 8;
	localparam logic [5:0]  IN_DIV_RESET   = 6'h00;
	localparam logic [4:0]  OUT_DIV_RESET  = 5'h00;
	// lock interval in oscillator cycles: base plus 1024 per input divider step
	localparam logic [16:0] LOCK_BASE_NEW  = 17'd512;
	localparam logic [16:0] LOCK_BASE_OLD  = 17'd128;
	localparam int          LOCK_STEP_SHIFT = 10;

	typedef enum logic [1:0] {
		LOOP_OFF,
		LOOP_COUNT,
		LOOP_LOCKED
	} plsd_loop_state_t;

	// sticky start-up fault record
	typedef struct packed {
		logic no_output;
		logic invalid_slip;
		logic valid_slip;
	} plsd_fault_t;
endpackage : plsd_pkg

// ### plsd_top.sv
/*
 * loop start-up sequencer: lock-time count, valid status, start-up fault
 * classification and glitch-free output divider, with an AXI4-Lite slave.
 * assumes slip flag and run indication arrive asynchronously from outside.
 */
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
module plsd_top (
	input  wire logic               REF_CLK,
	input  wire logic               SYS_RST,
	input  wire logic [7:0]         S_AXI_AWADDR,
	input  wire logic               S_AXI_AWVALID,
	output logic                    S_AXI_AWREADY,
	input  wire logic [31:0]        S_AXI_WDATA,
	input  wire logic [3:0]         S_AXI_WSTRB,
	input  wire logic               S_AXI_WVALID,
	output logic                    S_AXI_WREADY,
	output logic [1:0]              S_AXI_BRESP,
	output logic                    S_AXI_BVALID,
	input  wire logic               S_AXI_BREADY,
	input  wire logic [7:0]         S_AXI_ARADDR,
	input  wire logic               S_AXI_ARVALID,
	output logic                    S_AXI_ARREADY,
	output logic [31:0]             S_AXI_RDATA,
	output logic [1:0]              S_AXI_RRESP,
	output logic                    S_AXI_RVALID,
	input  wire logic               S_AXI_RREADY,
	input  wire logic               LOOP_SLIP,
	input  wire logic               LOOP_RUNNING,
	output logic                    LOOP_ENABLE,
	output logic                    CLOCK_SOURCE_VALID_STATUS,
	output plsd_pkg::plsd_fault_t   STARTUP_FAULT,
	output logic                    DERIVED_CLK_EN
);
	import plsd_pkg::*;

	logic                src_dis_q;
	logic                new_si_q;
	logic [5:0]          in_div_q;
	logic [4:0]          out_div_req_q;
	logic [4:0]          out_div_act_q;
	logic [4:0]          div_cnt_q;
	plsd_loop_state_t    state_q;
	logic [16:0]         lock_cnt_q;
	logic [16:0]         lock_target;
	logic                valid_q;
	logic                first_lock_q;
	plsd_fault_t         fault_q;
	logic                derived_en_q;
	logic [1:0]          s1_q;
	logic [1:0]          s2_q;
	logic [1:0]          s3_q;
	logic [1:0]          in_q;
	logic                slip;
	logic                running;
	logic                aw_have_q;
	logic                w_have_q;
	logic [7:0]          aw_addr_q;
	logic [31:0]         w_data_q;
	logic [3:0]          w_strb_q;
	logic                bvalid_q;
	logic [1:0]          bresp_q;
	logic                rvalid_q;
	logic [31:0]         rdata_q;
	logic [1:0]          rresp_q;
	logic                wr_fire;
	logic                wr_ctrl;
	logic                wr_div;
	logic                wr_fault;
	plsd_fault_t         fault_set;
	plsd_fault_t         fault_clr;

	// three-stage synchroniser; a change counts once stages two and three agree
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			s1_q <= 2'h0;
			s2_q <= 2'h0;
			s3_q <= 2'h0;
			in_q <= 2'h0;
		end else begin
			s1_q <= {LOOP_RUNNING, LOOP_SLIP};
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < 2; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					in_q[i] <= s3_q[i];
				end
			end
		end
	end
	assign slip    = in_q[0];
	assign running = in_q[1];

	// axi write path: address and data taken in either order, answered after both
	assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
	assign S_AXI_WREADY  = !w_have_q && !bvalid_q;
	assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;
	assign wr_ctrl       = wr_fire && aw_addr_q == ADDR_CTRL && w_strb_q[0];
	assign wr_div        = wr_fire && aw_addr_q == ADDR_DIV;
	assign wr_fault      = wr_fire && aw_addr_q == ADDR_FAULT && w_strb_q[0];

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_have_q <= 1'b1;
				w_data_q <= S_AXI_WDATA;
				w_strb_q <= S_AXI_WSTRB;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= (aw_addr_q == ADDR_CTRL || aw_addr_q == ADDR_DIV ||
					aw_addr_q == ADDR_STAT || aw_addr_q == ADDR_FAULT) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && S_AXI_BREADY) begin
				bvalid_q <= 1'b0;
			end
		end
	end
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP  = bresp_q;

	// axi read path: one cycle from address to data
	assign S_AXI_ARREADY = !rvalid_q;
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			rvalid_q <= 1'b1;
			rresp_q  <= RESP_OKAY;
			case (S_AXI_ARADDR)
				ADDR_CTRL:  rdata_q <= {30'h0, new_si_q, src_dis_q};
				ADDR_DIV:   rdata_q <= {11'h0, out_div_act_q, 3'h0, out_div_req_q, 2'h0, in_div_q};
				ADDR_STAT:  rdata_q <= {26'h0, out_div_act_q != out_div_req_q, first_lock_q,
					running, slip, state_q == LOOP_COUNT, valid_q};
				ADDR_FAULT: rdata_q <= {29'h0, fault_q};
				default: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && S_AXI_RREADY) begin
			rvalid_q <= 1'b0;
		end
	end
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA  = rdata_q;
	assign S_AXI_RRESP  = rresp_q;

	// control and divider registers
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			src_dis_q     <= CTRL_RESET[CTRL_DIS_BIT];
			new_si_q      <= CTRL_RESET[CTRL_NEW_BIT];
			in_div_q      <= IN_DIV_RESET;
			out_div_req_q <= OUT_DIV_RESET;
		end else begin
			if (wr_ctrl) begin
				src_dis_q <= w_data_q[CTRL_DIS_BIT];
				new_si_q  <= w_data_q[CTRL_NEW_BIT];
			end
			if (wr_div && w_strb_q[0]) begin
				in_div_q <= w_data_q[DIV_IN_LSB +: 6];
			end
			if (wr_div && w_strb_q[1]) begin
				out_div_req_q <= w_data_q[DIV_OUT_LSB +: 5];
			end
		end
	end
	assign LOOP_ENABLE = !src_dis_q;

	// lock interval from the silicon generation and the input divider
	assign lock_target = (new_si_q ? LOCK_BASE_NEW : LOCK_BASE_OLD)
		+ ({11'h0, in_div_q} << LOCK_STEP_SHIFT);

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			state_q    <= LOOP_OFF;
			lock_cnt_q <= 17'h0;
			valid_q    <= 1'b0;
		end else begin
			case (state_q)
				LOOP_OFF: begin
					valid_q <= 1'b0;
					if (!src_dis_q) begin
						// the edge that sees the enable is already the first lock cycle
						state_q    <= LOOP_COUNT;
						lock_cnt_q <= 17'h1;
					end else begin
						lock_cnt_q <= 17'h0;
					end
				end
				LOOP_COUNT: begin
					if (src_dis_q) begin
						state_q <= LOOP_OFF;
					end else if (lock_cnt_q + 17'h1 >= lock_target) begin
						state_q <= LOOP_LOCKED;
						valid_q <= 1'b1;
					end else begin
						lock_cnt_q <= lock_cnt_q + 17'h1;
					end
				end
				LOOP_LOCKED: begin
					if (src_dis_q) begin
						state_q <= LOOP_OFF;
						valid_q <= 1'b0;
					end
				end
				default: begin
					state_q <= LOOP_OFF;
					valid_q <= 1'b0;
				end
			endcase
		end
	end
	assign CLOCK_SOURCE_VALID_STATUS = valid_q;

	// start-up faults are only judged until the first clean lock after power-on
	always_comb begin
		fault_set              = '0;
		fault_clr              = '0;
		if (!first_lock_q && state_q != LOOP_OFF) begin
			fault_set.valid_slip   = valid_q && slip;
			fault_set.invalid_slip = !valid_q && slip;
			fault_set.no_output    = valid_q && !slip && !running;
		end
		if (wr_fault) begin
			fault_clr = plsd_fault_t'(w_data_q[2:0]);
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			fault_q      <= '0;
			first_lock_q <= 1'b0;
		end else begin
			// a new fault wins over a clear in the same cycle
			fault_q <= (fault_q & ~fault_clr) | fault_set;
			if (valid_q && !slip && running) begin
				first_lock_q <= 1'b1;
			end
		end
	end
	assign STARTUP_FAULT = fault_q;

	// derived clock enable; while valid, a new ratio is taken only at a period boundary
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			div_cnt_q     <= 5'h0;
			out_div_act_q <= OUT_DIV_RESET;
			derived_en_q  <= 1'b0;
		end else begin
			derived_en_q <= 1'b0;
			if (valid_q) begin
				if (div_cnt_q >= out_div_act_q) begin
					div_cnt_q     <= 5'h0;
					derived_en_q  <= 1'b1;
					out_div_act_q <= out_div_req_q;
				end else begin
					div_cnt_q <= div_cnt_q + 5'h1;
				end
			end else begin
				div_cnt_q     <= 5'h0;
				out_div_act_q <= out_div_req_q;
			end
		end
	end
	assign DERIVED_CLK_EN = derived_en_q;
endmodule : plsd_top

// ### plsd_chk.sv
/* port checks for the loop start-up block.
   bound into plsd_top; one oscillator clock, sync active-high reset. */
`timescale 1ns/100ps
module plsd_chk (
	input wire logic                  REF_CLK,
	input wire logic                  SYS_RST,
	input wire logic                  LOOP_ENABLE,
	input wire logic                  CLOCK_SOURCE_VALID_STATUS,
	input wire plsd_pkg::plsd_fault_t STARTUP_FAULT,
	input wire logic                  DERIVED_CLK_EN
);
	import plsd_pkg::*;
	// cycles since the loop was last enabled
	logic [16:0] en_cnt_q;
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST || !LOOP_ENABLE) begin
			en_cnt_q <= 17'h0;
		end else if (!(&en_cnt_q)) begin
			en_cnt_q <= en_cnt_q + 17'h1;
		end
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	sequence valid_up;
		$rose(CLOCK_SOURCE_VALID_STATUS);
	endsequence
	dis_drop_a: assert property (!LOOP_ENABLE |=> !CLOCK_SOURCE_VALID_STATUS)
		else $error("valid while loop off");
	lock_min_a: assert property (valid_up |-> en_cnt_q >= LOCK_BASE_OLD)
		else $error("lock too early");
	valid_en_a: assert property (valid_up |-> LOOP_ENABLE)
		else $error("valid without enable");
	clk_en_a: assert property (DERIVED_CLK_EN |-> $past(CLOCK_SOURCE_VALID_STATUS))
		else $error("clock enable while invalid");
	slip_valid_a: assert property ($rose(STARTUP_FAULT.valid_slip) |->
		$past(CLOCK_SOURCE_VALID_STATUS)) else $error("valid slip fault wrong");
	slip_inval_a: assert property ($rose(STARTUP_FAULT.invalid_slip) |->
		!$past(CLOCK_SOURCE_VALID_STATUS)) else $error("invalid slip fault wrong");
	no_out_a: assert property ($rose(STARTUP_FAULT.no_output) |->
		$past(CLOCK_SOURCE_VALID_STATUS)) else $error("no output fault wrong");
endmodule : plsd_chk

bind plsd_top plsd_chk i_chk (.*);

// ### test_pll_startup_divider_sequencing.sv
/* self-checking bench: registers, lock timing, fault patterns, divider.
   assumes plsd_pkg, plsd_top and the bound plsd_chk. */
`timescale 1ns/100ps
module test_pll_startup_divider_sequencing;
	import plsd_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, slip = 1'b0, run = 1'b0, drop = 1'b0;
	logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [7:0]  awa = 8'h0, ara = 8'h0;
	logic [31:0] wd = 32'h0, rdat;
	logic        awr, wrd, bv, arr, rv, en, vld, dce;
	logic [1:0]  bresp, rresp;
	logic [4:0]  rt[3] = '{5'h2, 5'h4, 5'h0};
	plsd_fault_t flt;
	int          n_fail = 0, cmp_count = 0, tmo = 0, cyc;
	always #25 clk = ~clk;
	plsd_top i_dut (.REF_CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .LOOP_SLIP(slip),
		.LOOP_RUNNING(run), .LOOP_ENABLE(en), .CLOCK_SOURCE_VALID_STATUS(vld),
		.STARTUP_FAULT(flt), .DERIVED_CLK_EN(dce));
	task close_out;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	always @(posedge clk) begin
		tmo <= tmo + 1;
		if (tmo == 12000) begin
			n_fail++;
			close_out;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task chk_rng(input int got, input int lo, input int hi);
		cmp_count++;
		if (got < lo || got > hi) begin
			n_fail++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, lo);
		end
	endtask : chk_rng
	// each channel released at the edge where its own handshake was seen
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic       ta, tw, tb;
		logic [1:0] r;
		tb = 1'b0;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		while (!tb) begin
			@(negedge clk);
			ta = awv & awr;
			tw = wv & wrd;
			tb = bv;
			r = bresp;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			if (tb) br <= 1'b0;
		end
		chk({30'h0, r}, {30'h0, er});
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
		logic        ta, tv;
		logic [31:0] d;
		logic [1:0]  r;
		tv = 1'b0;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		while (!tv) begin
			@(negedge clk);
			ta = arv & arr;
			tv = rv;
			d = rdat;
			r = rresp;
			@(posedge clk);
			if (ta) arv <= 1'b0;
			if (tv) rr <= 1'b0;
		end
		chk(d & m, e);
		chk({30'h0, r}, {30'h0, er});
	endtask : rd
	task wait_lock(input int lk);
		cyc = 0;
		do begin
			@(negedge clk);
			cyc++;
			if (drop && cyc == 20) begin
				@(posedge clk);
				slip <= 1'b0;
			end
		end while (vld !== 1'b1);
		chk_rng(cyc, lk, lk);
	endtask : wait_lock
	// fresh power-on, then one lock attempt and its fault record
	task trial(input logic [1:0] ctl, input logic [5:0] nr, input logic sl, input logic dr,
		input logic rn, input int lk, input logic [2:0] ef);
		@(posedge clk);
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		slip <= sl;
		run <= rn;
		drop = dr;
		wr(ADDR_DIV, {26'h0, nr}, RESP_OKAY);
		wr(ADDR_CTRL, {30'h0, ctl}, RESP_OKAY);
		wait_lock(lk);
		repeat (8) @(posedge clk);
		chk({29'h0, flt}, {29'h0, ef});
		rd(ADDR_FAULT, {29'h0, ef}, 32'h7, RESP_OKAY);
		slip <= 1'b0;
		run <= 1'b1;
		repeat (8) @(posedge clk);
		wr(ADDR_FAULT, 32'h7, RESP_OKAY);
		rd(ADDR_FAULT, 32'h0, 32'h7, RESP_OKAY);
		$display("lock trial done after %0d cycles", cyc);
	endtask : trial
	task per(input int p);
		int n;
		n = 0;
		repeat (12) @(posedge clk);
		while (dce !== 1'b1) @(negedge clk);
		do begin
			@(negedge clk);
			n++;
		end while (dce !== 1'b1);
		chk_rng(n, p, p);
	endtask : per
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(ADDR_CTRL, {30'h0, CTRL_RESET}, 32'h3, RESP_OKAY);
		rd(ADDR_DIV, 32'h0, 32'h1f3f, RESP_OKAY);
		rd(8'h10, 32'h0, 32'hffffffff, RESP_SLVERR);
		wr(8'h10, 32'h1, RESP_SLVERR);
		chk({31'h0, en}, 32'h0);
		$display("reset test done");
		trial(2'h0, 6'h0, 1'b1, 1'b1, 1'b1, 128, 3'h2);
		trial(2'h2, 6'h0, 1'b1, 1'b0, 1'b1, 512, 3'h3);
		trial(2'h2, 6'h0, 1'b0, 1'b0, 1'b0, 512, 3'h4);
		trial(2'h0, 6'h1, 1'b0, 1'b0, 1'b1, 1152, 3'h0);
		trial(2'h2, 6'h1, 1'b0, 1'b0, 1'b1, 1536, 3'h0);
		wr(ADDR_CTRL, 32'h3, RESP_OKAY);
		repeat (2) @(posedge clk);
		rd(ADDR_STAT, 32'h0, 32'h1, RESP_OKAY);
		slip <= 1'b1;
		wr(ADDR_CTRL, 32'h2, RESP_OKAY);
		wait_lock(1536);
		repeat (8) @(posedge clk);
		rd(ADDR_FAULT, 32'h0, 32'h7, RESP_OKAY);
		slip <= 1'b0;
		$display("re-enable test done");
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_DIV, {19'h0, rt[i], 8'h01}, RESP_OKAY);
			per(int'(rt[i]) + 1);
			rd(ADDR_DIV, {11'h0, rt[i], 3'h0, rt[i], 8'h01}, 32'h1f1f3f, RESP_OKAY);
		end
		$display("divider test done");
		close_out;
	end
endmodule : test_pll_startup_divider_sequencing
